/* File: rtl/four_level_interrupt_priority.sv */
`timescale 1ns/1ns

module four_level_interrupt_priority
   import four_level_interrupt_priority_pkg::*;
#(
   parameter bit HAS_COUNTER_ARRAY = 1'b1
)
(
   input  wire logic       I_CLK,
   input  wire logic       I_RESET,
   input  wire logic [7:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output logic      [7:0] O_RDATA,
   input  wire logic       I_EXT_ZERO_PIN_N,
   input  wire logic       I_EXT_ONE_PIN_N,
   input  wire logic       I_EXT_ZERO_TRANSITION_MODE,
   input  wire logic       I_EXT_ONE_TRANSITION_MODE,
   input  wire logic       I_TIMER_ZERO_OVERFLOW,
   input  wire logic       I_TIMER_ONE_OVERFLOW,
   input  wire logic       I_COUNTER_ARRAY_REQUEST,
   input  wire logic       I_SERIAL_REQUEST,
   input  wire logic       I_TIMER_TWO_REQUEST,
   output logic            O_INT_REQUEST,
   output logic      [7:0] O_VECTOR,
   input  wire logic       I_INT_ACK,
   input  wire logic       I_RETURN,
   output logic            O_IRQ
);

   logic [7:0]            source_enable_mask;
   logic [7:0]            priority_lower_bits;
   logic [7:0]            priority_upper_bits;
   logic [NUM_EVENTS-1:0] event_status;
   logic [NUM_EVENTS-1:0] event_mask;
   logic [3:0]            active_levels;
   logic [3:0]            next_active_levels;
   logic [3:0]            hw_flags;
   logic [2:0]            taken_index;
   logic [1:0]            taken_level;
   logic [1:0]            ext_zero_sync;
   logic [1:0]            ext_one_sync;
   logic                  ext_zero_prev;
   logic                  ext_one_prev;
   logic                  ext_zero_fall;
   logic                  ext_one_fall;
   logic                  ext_zero_request_flag;
   logic                  ext_one_request_flag;
   logic                  ack_taken;
   logic                  return_taken;
   logic [NUM_SOURCES-1:0] source_flag;
   logic [NUM_SOURCES-1:0] source_eligible;
   logic [1:0]            source_level [NUM_SOURCES];
   logic                  win_found;
   logic [2:0]            win_index;
   logic [1:0]            win_level;
   logic                  write_hit_flags;
   logic [NUM_EVENTS-1:0] event_set;

   // External pins come from outside the clock domain
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         ext_zero_sync <= 2'h3;
         ext_one_sync  <= 2'h3;
         ext_zero_prev <= 1'b1;
         ext_one_prev  <= 1'b1;
      end
      else
      begin
         ext_zero_sync <= {ext_zero_sync[0], I_EXT_ZERO_PIN_N};
         ext_one_sync  <= {ext_one_sync[0], I_EXT_ONE_PIN_N};
         ext_zero_prev <= ext_zero_sync[1];
         ext_one_prev  <= ext_one_sync[1];
      end
   end

   // Edge detect only looks at the second synchroniser stage
   assign ext_zero_fall = ext_zero_prev & ~ext_zero_sync[1];
   assign ext_one_fall  = ext_one_prev & ~ext_one_sync[1];

   assign ack_taken    = I_INT_ACK & O_INT_REQUEST;
   assign return_taken = I_RETURN;
   assign write_hit_flags = I_WR && (I_ADDR == ADDR_HW_FLAGS);

   // Edge-captured and timer flags; a new event beats any clear
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         hw_flags <= 4'h0;
      end
      else
      begin
         for (int f = 0; f < 4; f++)
         begin
            if (write_hit_flags && I_WDATA[f])
            begin
               hw_flags[f] <= 1'b0;
            end
         end
         // Vectoring clears the flag of timer zero or timer one when taken, or of an external source taken in transition mode
         if (ack_taken)
         begin
            if (taken_index == 3'(SRC_EXT_ZERO)
                && I_EXT_ZERO_TRANSITION_MODE)
            begin
               hw_flags[HWF_EXT_ZERO] <= 1'b0;
            end
            if (taken_index == 3'(SRC_EXT_ONE)
                && I_EXT_ONE_TRANSITION_MODE)
            begin
               hw_flags[HWF_EXT_ONE] <= 1'b0;
            end
            if (taken_index == 3'(SRC_TMR_ZERO))
            begin
               hw_flags[HWF_TMR_ZERO] <= 1'b0;
            end
            if (taken_index == 3'(SRC_TMR_ONE))
            begin
               hw_flags[HWF_TMR_ONE] <= 1'b0;
            end
         end
         if (ext_zero_fall)
         begin
            hw_flags[HWF_EXT_ZERO] <= 1'b1;
         end
         if (ext_one_fall)
         begin
            hw_flags[HWF_EXT_ONE] <= 1'b1;
         end
         if (I_TIMER_ZERO_OVERFLOW)
         begin
            hw_flags[HWF_TMR_ZERO] <= 1'b1;
         end
         if (I_TIMER_ONE_OVERFLOW)
         begin
            hw_flags[HWF_TMR_ONE] <= 1'b1;
         end
      end
   end

   // Level mode follows the pin, so only software at the source ends it
   assign ext_zero_request_flag = I_EXT_ZERO_TRANSITION_MODE ?
                                  hw_flags[HWF_EXT_ZERO] :
                                  ~ext_zero_sync[1];
   assign ext_one_request_flag  = I_EXT_ONE_TRANSITION_MODE ?
                                  hw_flags[HWF_EXT_ONE] :
                                  ~ext_one_sync[1];

   // Request flags in polling order
   always_comb
   begin
      source_flag = '0;
      source_flag[SRC_EXT_ZERO]  = ext_zero_request_flag;
      source_flag[SRC_TMR_ZERO]  = hw_flags[HWF_TMR_ZERO];
      source_flag[SRC_EXT_ONE]   = ext_one_request_flag;
      source_flag[SRC_TMR_ONE]   = hw_flags[HWF_TMR_ONE];
      source_flag[SRC_CNT_ARRAY] = HAS_COUNTER_ARRAY
                                   & I_COUNTER_ARRAY_REQUEST;
      source_flag[SRC_SERIAL]    = I_SERIAL_REQUEST;
      source_flag[SRC_TMR_TWO]   = I_TIMER_TWO_REQUEST;
   end

   // Level, gating and blocking by services already in progress
   always_comb
   begin
      source_eligible = '0;
      for (int s = 0; s < NUM_SOURCES; s++)
      begin
         source_level[s] = {priority_upper_bits[SRC_BIT[s]],
                            priority_lower_bits[SRC_BIT[s]]};
         source_eligible[s] = source_flag[s]
                              & source_enable_mask[SRC_BIT[s]]
                              & source_enable_mask[GLOBAL_ENABLE_BIT]
                              & ((active_levels >> source_level[s])
                                 == 4'h0);
      end
   end

   // First source in order among those at the highest level wins
   always_comb
   begin
      win_found = 1'b0;
      win_index = 3'h0;
      win_level = 2'h0;
      for (int s = 0; s < NUM_SOURCES; s++)
      begin
         if (source_eligible[s]
             && (!win_found || source_level[s] > win_level))
         begin
            win_found = 1'b1;
            win_index = 3'(s);
            win_level = source_level[s];
         end
      end
   end

   // Request and vector are registered; a taken request drops for a
   // cycle so the core never sees a stale vector after acknowledge
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         O_INT_REQUEST <= 1'b0;
         O_VECTOR      <= RESET_VECTOR;
         taken_index   <= 3'h0;
         taken_level   <= 2'h0;
      end
      else
      begin
         O_INT_REQUEST <= win_found & ~ack_taken & ~return_taken;
         O_VECTOR      <= SRC_VECTOR[win_index];
         taken_index   <= win_index;
         taken_level   <= win_level;
      end
   end

   // One in-progress bit per level holds the nesting record
   always_comb
   begin
      next_active_levels = active_levels;
      if (return_taken)
      begin
         // The highest level in progress is the one finishing
         for (int l = 0; l < NUM_LEVELS; l++)
         begin
            if ((active_levels >> l) == 4'h1)
            begin
               next_active_levels[l] = 1'b0;
            end
         end
      end
      else if (ack_taken)
      begin
         next_active_levels[taken_level] = 1'b1;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         active_levels <= RESET_ACTIVE;
      end
      else
      begin
         active_levels <= next_active_levels;
      end
   end

   // Software-visible registers
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         source_enable_mask  <= RESET_ENABLE_MASK;
         priority_lower_bits <= RESET_PRIORITY;
         priority_upper_bits <= RESET_PRIORITY;
         event_mask          <= RESET_EVENT_MASK[NUM_EVENTS-1:0];
      end
      else if (I_WR)
      begin
         case (I_ADDR)
            ADDR_SOURCE_ENABLE_MASK:
            begin
               source_enable_mask <= I_WDATA;
               // Enable bit of an absent counter array stays clear
               source_enable_mask[CNT_ARRAY_ENABLE_BIT] <=
                  I_WDATA[CNT_ARRAY_ENABLE_BIT] & HAS_COUNTER_ARRAY;
            end
            ADDR_PRIORITY_LOWER_BITS:
            begin
               priority_lower_bits <= I_WDATA;
            end
            ADDR_PRIORITY_UPPER_BITS:
            begin
               priority_upper_bits <= I_WDATA;
            end
            ADDR_EVENT_MASK:
            begin
               event_mask <= I_WDATA[NUM_EVENTS-1:0];
            end
            default:
            begin
            end
         endcase
      end
   end

   // Controller events for the housekeeping interrupt
   always_comb
   begin
      event_set = '0;
      event_set[EV_SERVICE_START] = ack_taken & ~return_taken;
      event_set[EV_SERVICE_END]   = return_taken & (active_levels != 4'h0);
      event_set[EV_PREEMPT]       = ack_taken & ~return_taken
                                    & (active_levels != 4'h0);
      event_set[EV_STRAY_RETURN]  = return_taken & (active_levels == 4'h0);
   end

   // Write one clears; an event in the same cycle wins
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         event_status <= '0;
      end
      else
      begin
         if (I_WR && I_ADDR == ADDR_EVENT_STATUS)
         begin
            event_status <= (event_status & ~I_WDATA[NUM_EVENTS-1:0])
                            | event_set;
         end
         else
         begin
            event_status <= event_status | event_set;
         end
      end
   end

   assign O_IRQ = |(event_status & event_mask);

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         O_RDATA <= 8'h00;
      end
      else if (I_RD)
      begin
         case (I_ADDR)
            ADDR_SOURCE_ENABLE_MASK:  O_RDATA <= source_enable_mask;
            ADDR_PRIORITY_LOWER_BITS: O_RDATA <= priority_lower_bits;
            ADDR_PRIORITY_UPPER_BITS: O_RDATA <= priority_upper_bits;
            ADDR_EVENT_STATUS:        O_RDATA <= {4'h0, event_status};
            ADDR_EVENT_MASK:          O_RDATA <= {4'h0, event_mask};
            ADDR_SERVICE_STATE:       O_RDATA <= {4'h0, active_levels};
            ADDR_HW_FLAGS:            O_RDATA <= {4'h0, hw_flags};
            default:                  O_RDATA <= 8'h00;
         endcase
      end
      else
      begin
         O_RDATA <= 8'h00;
      end
   end

endmodule

/* File: shared/four_level_interrupt_priority_pkg.sv */
package four_level_interrupt_priority_pkg;

   // Source order is also the tie-break order within one level
   localparam int NUM_SOURCES   = 7;
   localparam int NUM_LEVELS    = 4;
   localparam int SRC_EXT_ZERO  = 0;
   localparam int SRC_TMR_ZERO  = 1;
   localparam int SRC_EXT_ONE   = 2;
   localparam int SRC_TMR_ONE   = 3;
   localparam int SRC_CNT_ARRAY = 4;
   localparam int SRC_SERIAL    = 5;
   localparam int SRC_TMR_TWO   = 6;

   // Register offsets on the 8-bit register port
   localparam logic [7:0] ADDR_SOURCE_ENABLE_MASK  = 8'hA8;
   localparam logic [7:0] ADDR_PRIORITY_UPPER_BITS = 8'hB7;
   localparam logic [7:0] ADDR_PRIORITY_LOWER_BITS = 8'hB8;
   localparam logic [7:0] ADDR_EVENT_STATUS        = 8'hC0;
   localparam logic [7:0] ADDR_EVENT_MASK          = 8'hC1;
   localparam logic [7:0] ADDR_SERVICE_STATE       = 8'hC2;
   localparam logic [7:0] ADDR_HW_FLAGS            = 8'hC3;

   // Bit positions of each source inside enable and priority registers
   localparam int SRC_BIT [NUM_SOURCES] = '{0, 1, 2, 3, 6, 4, 5};
   localparam int GLOBAL_ENABLE_BIT     = 7;
   localparam int CNT_ARRAY_ENABLE_BIT  = 6;

   // Vector address of each source, in source order
   localparam logic [7:0] SRC_VECTOR [NUM_SOURCES] =
      '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h33, 8'h23, 8'h2B};

   // Event status bits
   localparam int EV_SERVICE_START = 0;
   localparam int EV_SERVICE_END   = 1;
   localparam int EV_PREEMPT       = 2;
   localparam int EV_STRAY_RETURN  = 3;
   localparam int NUM_EVENTS       = 4;

   // Hardware-owned flag bits in the flag register
   localparam int HWF_EXT_ZERO = 0;
   localparam int HWF_TMR_ZERO = 1;
   localparam int HWF_EXT_ONE  = 2;
   localparam int HWF_TMR_ONE  = 3;

   // Values after reset
   localparam logic [7:0] RESET_ENABLE_MASK = 8'h00;
   localparam logic [7:0] RESET_PRIORITY    = 8'h00;
   localparam logic [7:0] RESET_EVENT_MASK  = 8'h00;
   localparam logic [7:0] RESET_VECTOR      = 8'h00;
   localparam logic [3:0] RESET_ACTIVE      = 4'h0;

endpackage

/* File: verification/four_level_interrupt_priority_sva.sv */
`timescale 1ns/1ns
module four_level_interrupt_priority_sva
(
   input wire logic       I_CLK,
   input wire logic       I_RESET,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic       I_WR,
   input wire logic       I_RD,
   input wire logic [7:0] O_RDATA,
   input wire logic       I_INT_ACK,
   input wire logic       I_RETURN,
   input wire logic       O_INT_REQUEST,
   input wire logic [7:0] O_VECTOR,
   input wire logic       O_IRQ
);
   logic       glob;
   logic [3:0] emask;
   logic [2:0] depth;

   default clocking dc @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   // Shadows of the global enable and event mask, seen from the bus
   always_ff @(posedge I_CLK)
      if (I_RESET)
      begin
         glob  <= 1'b0;
         emask <= 4'h0;
      end
      else if (I_WR && I_ADDR == 8'hA8)
         glob <= I_WDATA[7];
      else if (I_WR && I_ADDR == 8'hC1)
         emask <= I_WDATA[3:0];

   // Nesting depth; a return beats an ack in the same cycle
   always_ff @(posedge I_CLK)
      if (I_RESET)
         depth <= 3'h0;
      else if (I_RETURN)
         depth <= (depth == 3'h0) ? depth : depth - 3'h1;
      else if (I_INT_ACK && O_INT_REQUEST)
         depth <= depth + 3'h1;

   sequence s_take;
      I_INT_ACK && O_INT_REQUEST && !I_RETURN;
   endsequence

   sequence s_odd_read;
      I_RD && I_ADDR < 8'hA8;
   endsequence

   a_ack_drops_req: assert property (s_take |=> !O_INT_REQUEST)
      else $error("request stays up after ack");
   a_vector_legal: assert property (
      O_INT_REQUEST |-> O_VECTOR inside
      {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h33, 8'h23, 8'h2B})
      else $error("vector outside the table");
   a_global_mask: assert property (
      !glob && !$past(glob) |-> !O_INT_REQUEST)
      else $error("request with global enable off");
   a_nest_full: assert property (
      depth == 3'h4 |-> !O_INT_REQUEST)
      else $error("request above the top level");
   a_irq_masked: assert property (emask == 4'h0 |-> !O_IRQ)
      else $error("irq with all events masked");
   a_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
      else $error("read data outside its cycle");
   a_odd_read: assert property (s_odd_read |=> O_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (disable iff (1'b0)
      I_RESET |=> !O_INT_REQUEST && !O_IRQ && O_RDATA == 8'h00)
      else $error("outputs busy in reset");
endmodule

bind four_level_interrupt_priority four_level_interrupt_priority_sva i_sva (
   .I_CLK, .I_RESET, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
   .I_INT_ACK, .I_RETURN, .O_INT_REQUEST, .O_VECTOR, .O_IRQ);

/* File: verification/core_service_model.sv */
`timescale 1ns/1ns
module core_service_model
(
   input  wire logic       i_clk,
   input  wire logic       i_req,
   input  wire logic [1:0] i_delay,
   input  wire logic       i_ret_cmd,
   output logic            o_ack,
   output logic            o_ret
);
   logic [1:0] wait_cnt = 2'h0;

   initial
   begin
      o_ack = 1'b0;
      o_ret = 1'b0;
   end

   // Takes a request after a chosen wait; never acks twice in a row
   always @(posedge i_clk)
   begin
      o_ack <= 1'b0;
      o_ret <= i_ret_cmd;
      if (!i_req || o_ack)
         wait_cnt <= 2'h0;
      else if (wait_cnt >= i_delay)
         o_ack <= 1'b1;
      else
         wait_cnt <= wait_cnt + 2'h1;
   end
endmodule

/* File: verification/tb_four_level_interrupt_priority.sv */
`timescale 1ns/1ns
module tb_four_level_interrupt_priority
   import four_level_interrupt_priority_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [6:0]  lv = 7'h00;
   logic [1:0]  tm = 2'h0;
   logic [1:0]  trn = 2'h0;
   logic        ret_cmd = 1'b0;
   logic [1:0]  dly = 2'h0;
   logic        rd_seen = 1'b0;
   logic        ack_seen = 1'b0;
   logic        ack, ret, req, irq;
   logic [7:0]  rdata, vec, vec_seen;
   logic        req_six;
   logic [7:0]  rdata_six;
   logic [31:0] lf = 32'hEDEC;
   logic [7:0]  exp_rd[$], exp_vec[$];
   logic [7:0]  map [8] = '{8'hA8, 8'hB7, 8'hB8, 8'hC0, 8'hC1, 8'hC2,
                            8'hC3, 8'h55};
   int          fails = 0;
   int          n_tests = 0;

   always #4 clk = ~clk;

   four_level_interrupt_priority i_dut (
      .I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_EXT_ZERO_PIN_N(~lv[0]), .I_EXT_ONE_PIN_N(~lv[2]),
      .I_EXT_ZERO_TRANSITION_MODE(trn[0]),
      .I_EXT_ONE_TRANSITION_MODE(trn[1]),
      .I_TIMER_ZERO_OVERFLOW(tm[0]), .I_TIMER_ONE_OVERFLOW(tm[1]),
      .I_COUNTER_ARRAY_REQUEST(lv[4]), .I_SERIAL_REQUEST(lv[5]),
      .I_TIMER_TWO_REQUEST(lv[6]), .O_INT_REQUEST(req), .O_VECTOR(vec),
      .I_INT_ACK(ack), .I_RETURN(ret), .O_IRQ(irq));

   // Six-source variant; only its enable register and request are watched
   four_level_interrupt_priority #(.HAS_COUNTER_ARRAY(1'b0)) i_dut_six (
      .I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata_six),
      .I_EXT_ZERO_PIN_N(~lv[0]), .I_EXT_ONE_PIN_N(~lv[2]),
      .I_EXT_ZERO_TRANSITION_MODE(trn[0]),
      .I_EXT_ONE_TRANSITION_MODE(trn[1]),
      .I_TIMER_ZERO_OVERFLOW(tm[0]), .I_TIMER_ONE_OVERFLOW(tm[1]),
      .I_COUNTER_ARRAY_REQUEST(lv[4]), .I_SERIAL_REQUEST(lv[5]),
      .I_TIMER_TWO_REQUEST(lv[6]), .O_INT_REQUEST(req_six), .O_VECTOR(),
      .I_INT_ACK(1'b0), .I_RETURN(1'b0), .O_IRQ());

   core_service_model i_core (.i_clk(clk), .i_req(req), .i_delay(dly),
      .i_ret_cmd(ret_cmd), .o_ack(ack), .o_ret(ret));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string w, input logic [7:0] e, s);
      n_tests++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", w, e, s);
      end
   endtask

   task automatic wr8(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd8(input logic [7:0] a, e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_rd.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   task automatic pulse(input logic [1:0] t);
      @(posedge clk);
      tm <= t;
      @(posedge clk);
      tm <= 2'h0;
   endtask

   // Bounded wait until the watcher has matched every noted vector
   task automatic hold_on();
      repeat (40) if (exp_vec.size() != 0) @(posedge clk);
      if (exp_vec.size() != 0)
      begin
         fails++;
         $display("Error ack expected %h seen none", exp_vec[0]);
         exp_vec.delete();
      end
   endtask

   task automatic take(input logic [7:0] v);
      exp_vec.push_back(v);
      dly <= lf[1:0];
      lf = lfsr(lf);
      hold_on();
   endtask

   task automatic give_back();
      @(posedge clk);
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic test_done();
      $display("Checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Note at the edge, compare at the falling edge once outputs settle;
   // an ack with no note pops an empty queue and so mismatches
   always @(posedge clk)
   begin
      rd_seen <= rd;
      ack_seen <= ack && req && !ret;
      vec_seen <= vec;
   end

   always @(negedge clk)
   begin
      if (rd_seen)
         chk("read", exp_rd.pop_front(), rdata);
      if (ack_seen)
         chk("vector", exp_vec.pop_front(), vec_seen);
   end

   initial
   begin
      #100000;
      fails++;
      $display("Error watchdog expired");
      test_done();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wr8(8'h55, lf[7:0]);
      foreach (map[i]) rd8(map[i], 8'h00);
      wr8(8'hC1, lf[7:0]);
      rd8(8'hC1, {4'h0, lf[3:0]});
      lf = lfsr(lf);
      wr8(8'hC1, 8'h00);
      // Every source at level 0, first held back by the global enable
      trn <= 2'h3;
      lv <= 7'h75;
      wr8(8'hA8, 8'h7F);
      pulse(2'h3);
      repeat (20) @(posedge clk);
      rd8(8'hC3, 8'h0F);
      wr8(8'hA8, 8'hFF);
      for (int i = 0; i < NUM_SOURCES; i++)
      begin
         take(SRC_VECTOR[i]);
         lv[i] <= 1'b0;
         give_back();
      end
      rd8(8'hC3, 8'h00);
      // Climb all four levels, each preempting the one below
      trn <= 2'h0;
      wr8(8'hB8, 8'h1A);
      wr8(8'hB7, 8'h1C);
      wr8(8'hA8, 8'h9F);
      lv[0] <= 1'b1;
      take(8'h03);
      lv[0] <= 1'b0;
      pulse(2'h1);
      take(8'h0B);
      lv[2] <= 1'b1;
      take(8'h13);
      lv[2] <= 1'b0;
      pulse(2'h2);
      take(8'h1B);
      rd8(8'hC2, 8'h0F);
      lv[5] <= 1'b1;
      repeat (15) @(posedge clk);
      exp_vec.push_back(8'h23);
      give_back();
      hold_on();
      lv[5] <= 1'b0;
      rd8(8'hC2, 8'h0F);
      repeat (4) give_back();
      rd8(8'hC2, 8'h00);
      rd8(8'hC0, 8'h07);
      // A stray return raises its own event; the mask gates the line
      wr8(8'hC0, 8'h0F);
      give_back();
      rd8(8'hC0, 8'h08);
      @(negedge clk);
      chk("irq", 8'h00, {7'h0, irq});
      wr8(8'hC1, 8'h08);
      @(negedge clk);
      chk("irq", 8'h01, {7'h0, irq});
      wr8(8'hC0, 8'h08);
      @(negedge clk);
      chk("irq", 8'h00, {7'h0, irq});
      // Counter array request: served by the full part, never by the
      // six-source part, whose enable bit for it reads back clear
      wr8(8'hA8, 8'hC0);
      exp_vec.push_back(8'h33);
      lv[4] <= 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("six request", 8'h00, {7'h0, req_six});
      hold_on();
      @(posedge clk);
      lv[4] <= 1'b0;
      give_back();
      rd8(8'hA8, 8'hC0);
      @(negedge clk);
      chk("six enable", 8'h80, rdata_six);
      test_done();
   end
endmodule
